// ===== design/pmc_pwm_counter.sv
// PWM mode counter channel with APB register slave
// What this block does
// - Ascending mode: terminal_event equals overflow.
// - Descending and single up/down modes: terminal_event equals underflow only.
// - Dual up/down mode: terminal_event on overflow or underflow.
// - Ascending/descending: compare_hit when counter moves into compare_value.
// - Up/down modes: compare_hit when counter leaves compare_value.
// - Output uses only active cycle_length and compare_value, never shadows.
// - Swap request while running stays pending until next terminal_event.
// - One register write can raise swap on several counters at once.
// - Ascending: leaving cycle_length gives overflow and terminal_event.
// - Descending: leaving zero gives underflow, terminal_event, reload of cycle_length.
// - Single up/down: overflow at cycle_length, underflow plus terminal_event at zero.
// - Up/down modes: value before reload counts as zero for compare_hit.
// - Halt_on_shutdown set: kill stops the counter.
// - Non-latched kill, halt_on_shutdown clear: counter runs, outputs suppressed while kill lasts.
// - Latched kill: outputs suppressed until terminal_event without kill.
// - Idle outputs take their own polarity level.
// - Constant-active swap: exchange at every terminal_event.
// - Dual up/down mode also swaps compare_value at overflow.
// - Dual mode: compare 0 at underflow or cycle_length at overflow hits.
// - Reload sets counter and direction by mode.
// - Overflow leaves cycle_length upward; underflow leaves zero downward.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_params.svh"

module pmc_pwm_counter (
  input  wire logic                pclk,
  input  wire logic                sys_rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                kill_in,
  input  wire logic                swap_group_in,
  output logic                     swap_group_out,
  output logic                     pwm_out,
  output logic                     pwm_comp_out,
  output pmc_pkg::pmc_evt_s        evt_out
);
  logic                     kill_meta_q;
  logic                     kill_s_q;
  logic [`PMC_CTRL_MSB:0]   ctrl_q;
  logic [`PMC_CTRL_MSB:0]   ctrl_d;
  pmc_pkg::pmc_ctrl_s       ctrl;
  logic [`PMC_W-1:0]        cyc_q;
  logic [`PMC_W-1:0]        cyc_d;
  logic [`PMC_W-1:0]        cyc_sh_q;
  logic [`PMC_W-1:0]        cyc_sh_d;
  logic [`PMC_W-1:0]        cmp_q;
  logic [`PMC_W-1:0]        cmp_d;
  logic [`PMC_W-1:0]        cmp_sh_q;
  logic [`PMC_W-1:0]        cmp_sh_d;
  logic [`PMC_W-1:0]        presc_q;
  logic [`PMC_W-1:0]        presc_d;
  logic [`PMC_W-1:0]        pcnt_q;
  logic [`PMC_W-1:0]        pcnt_d;
  logic [`PMC_W-1:0]        cnt_q;
  logic [`PMC_W-1:0]        cnt_d;
  logic                     dir_up_q;
  logic                     dir_up_d;
  logic                     run_q;
  logic                     run_d;
  logic                     pend_q;
  logic                     pend_d;
  logic                     supp_q;
  logic                     supp_d;
  logic                     wave_q;
  logic                     wave_d;
  logic                     pwm_q;
  logic                     pwm_d;
  logic                     pwmc_q;
  logic                     pwmc_d;
  pmc_pkg::pmc_evt_s        evt_q;
  pmc_pkg::pmc_evt_s        evt_d;
  logic                     wr;
  logic                     rd;
  logic [`PMC_AW-1:0]       addr;
  logic                     mapped;
  logic                     cmd_wr;
  logic                     tick;
  logic                     swap_ev;
  logic                     do_swap;
  logic                     ovf;
  logic                     unf;
  logic                     tc;
  logic                     hit;
  logic                     active;

  assign ctrl   = pmc_pkg::pmc_ctrl_s'(ctrl_q);
  assign addr   = paddr[`PMC_AW-1:0];
  assign pready = 1'b1;
  assign mapped = (paddr[31:`PMC_AW] == '0) && (paddr[1:0] == 2'b00) &&
                  (addr <= `PMC_OFF_PRESC);
  assign wr     = psel && penable && pwrite && mapped && (pstrb != 4'h0);
  assign rd     = psel && penable && !pwrite;
  assign cmd_wr = wr && (addr == `PMC_OFF_CMD);
  // Same write pulse fans out to sibling channels sharing the period
  assign swap_group_out = cmd_wr && pwdata[`PMC_CMD_SWAP];
  assign pslverr = psel && penable && !mapped;
  assign evt_out      = evt_q;
  assign pwm_out      = pwm_q;
  assign pwm_comp_out = pwmc_q;

  // Bus read mux, registered only through state it reads
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd && mapped) begin
      case (addr)
        `PMC_OFF_CTRL:   prdata = {21'h00_0000, ctrl_q};
        `PMC_OFF_STAT:   prdata = {27'h000_0000, supp_q, kill_s_q, pend_q, dir_up_q, run_q};
        `PMC_OFF_CNT:    prdata = {16'h0000, cnt_q};
        `PMC_OFF_CYC:    prdata = {16'h0000, cyc_q};
        `PMC_OFF_CYC_SH: prdata = {16'h0000, cyc_sh_q};
        `PMC_OFF_CMP:    prdata = {16'h0000, cmp_q};
        `PMC_OFF_CMP_SH: prdata = {16'h0000, cmp_sh_q};
        `PMC_OFF_PRESC:  prdata = {16'h0000, presc_q};
        default:         prdata = 32'h0000_0000;
      endcase
    end
  end

  // Counter, swap, kill and wave next state
  always_comb begin
    ctrl_d   = ctrl_q;
    cyc_d    = cyc_q;
    cyc_sh_d = cyc_sh_q;
    cmp_d    = cmp_q;
    cmp_sh_d = cmp_sh_q;
    presc_d  = presc_q;
    pcnt_d   = pcnt_q;
    cnt_d    = cnt_q;
    dir_up_d = dir_up_q;
    run_d    = run_q;
    supp_d   = supp_q;
    wave_d   = wave_q;
    ovf      = 1'b0;
    unf      = 1'b0;
    hit      = 1'b0;
    tick     = 1'b0;

    // Prescaler: count clock is one pclk every presc+1 cycles
    if (run_q) begin
      if (pcnt_q >= presc_q) begin
        pcnt_d = `PMC_ZERO;
        tick   = 1'b1;
      end else begin
        pcnt_d = pcnt_q + `PMC_ONE;
      end
    end else begin
      pcnt_d = `PMC_ZERO;
    end

    if (tick) begin
      case (ctrl.mode)
        pmc_pkg::PMC_ASCENDING: begin
          if (cnt_q == cyc_q) begin
            ovf   = 1'b1;
            cnt_d = `PMC_ZERO;
          end else begin
            cnt_d = cnt_q + `PMC_ONE;
          end
          hit = (cnt_d == cmp_q);
        end
        pmc_pkg::PMC_DESCENDING: begin
          if (cnt_q == `PMC_ZERO) begin
            unf   = 1'b1;
            cnt_d = cyc_q;
          end else begin
            cnt_d = cnt_q - `PMC_ONE;
          end
          hit = (cnt_d == cmp_q);
        end
        default: begin
          hit = (cnt_q == cmp_q);
          if (dir_up_q) begin
            if (cnt_q == cyc_q) begin
              ovf      = 1'b1;
              dir_up_d = 1'b0;
              cnt_d    = cnt_q - `PMC_ONE;
            end else begin
              cnt_d = cnt_q + `PMC_ONE;
            end
          end else begin
            if (cnt_q == `PMC_ZERO) begin
              unf      = 1'b1;
              dir_up_d = 1'b1;
              cnt_d    = `PMC_ONE;
            end else begin
              cnt_d = cnt_q - `PMC_ONE;
            end
          end
        end
      endcase
    end

    case (ctrl.mode)
      pmc_pkg::PMC_ASCENDING:  tc = ovf;
      pmc_pkg::PMC_DESCENDING: tc = unf;
      pmc_pkg::PMC_UPDN_SGL:   tc = unf;
      pmc_pkg::PMC_UPDN_DUAL:  tc = ovf || unf;
      default:                 tc = 1'b0;
    endcase

    // Pending request or constant-active trigger exchanges on terminal_event
    do_swap = tc && (pend_q || swap_ev || ctrl.swap_const);
    if (do_swap) begin
      if (ctrl.auto_cc) begin
        cmp_d    = cmp_sh_q;
        cmp_sh_d = cmp_q;
      end
      if (ctrl.auto_period) begin
        cyc_d    = cyc_sh_q;
        cyc_sh_d = cyc_q;
      end
    end

    // Wave shaping from terminal and compare events
    if (tick) begin
      case (ctrl.mode)
        pmc_pkg::PMC_ASCENDING: begin
          if (hit) begin
            wave_d = 1'b0;
          end else if (tc) begin
            wave_d = 1'b1;
          end
        end
        pmc_pkg::PMC_DESCENDING: begin
          if (hit) begin
            wave_d = 1'b1;
          end else if (tc) begin
            wave_d = 1'b0;
          end
        end
        default: begin
          if (hit) begin
            wave_d = dir_up_q;
          end
        end
      endcase
    end

    // Kill handling: halt on any pclk, suppression on the active count clock
    if (run_q && kill_s_q && ctrl.halt_on_shutdown) begin
      run_d = 1'b0;
    end else if (tick) begin
      if (!ctrl.latched_shutdown) begin
        supp_d = kill_s_q;
      end else if (kill_s_q) begin
        supp_d = 1'b1;
      end else if (tc) begin
        supp_d = 1'b0;
      end
    end

    if (tick && ctrl.one_shot && tc && !(ctrl.mode == pmc_pkg::PMC_UPDN_DUAL && ovf)) begin
      run_d = 1'b0;
    end

    if (cmd_wr && pwdata[`PMC_CMD_STOP]) begin
      run_d = 1'b0;
    end else if (cmd_wr && !run_q && ctrl.enable &&
                 (pwdata[`PMC_CMD_RELOAD] || pwdata[`PMC_CMD_START])) begin
      run_d  = 1'b1;
      supp_d = 1'b0;
      case (ctrl.mode)
        pmc_pkg::PMC_ASCENDING:  dir_up_d = 1'b1;
        pmc_pkg::PMC_DESCENDING: dir_up_d = 1'b0;
        default:                 dir_up_d = 1'b1;
      endcase
      if (pwdata[`PMC_CMD_RELOAD]) begin
        case (ctrl.mode)
          pmc_pkg::PMC_ASCENDING: begin
            cnt_d  = `PMC_ZERO;
            wave_d = (cmp_q != `PMC_ZERO);
          end
          pmc_pkg::PMC_DESCENDING: begin
            cnt_d  = cyc_q;
            wave_d = (cmp_q == cyc_q);
          end
          default: begin
            cnt_d  = `PMC_ONE;
            wave_d = (cmp_q == `PMC_ZERO);
          end
        endcase
      end
    end
    if (!ctrl.enable) begin
      run_d = 1'b0;
    end

    // Bus writes win over hardware exchange for the same register
    if (wr) begin
      case (addr)
        `PMC_OFF_CTRL:   ctrl_d   = pwdata[`PMC_CTRL_MSB:0];
        `PMC_OFF_CYC:    cyc_d    = pwdata[`PMC_W-1:0];
        `PMC_OFF_CYC_SH: cyc_sh_d = pwdata[`PMC_W-1:0];
        `PMC_OFF_CMP:    cmp_d    = pwdata[`PMC_W-1:0];
        `PMC_OFF_CMP_SH: cmp_sh_d = pwdata[`PMC_W-1:0];
        `PMC_OFF_PRESC:  presc_d  = pwdata[`PMC_W-1:0];
        `PMC_OFF_CNT:    cnt_d    = run_q ? cnt_d : pwdata[`PMC_W-1:0];
        default:         ctrl_d   = ctrl_d;
      endcase
    end
  end

  // Swap request from own write or a sibling's broadcast
  assign swap_ev = (cmd_wr && pwdata[`PMC_CMD_SWAP]) || swap_group_in;

  always_comb begin
    pend_d = pend_q;
    if (!run_q) begin
      pend_d = 1'b0;
    end else if (swap_ev) begin
      pend_d = !do_swap;
    end else if (do_swap) begin
      pend_d = 1'b0;
    end
  end

  // Output stage: idle and suppressed outputs sit at their polarity level
  always_comb begin
    active = run_q && !supp_q && !(kill_s_q && ctrl.halt_on_shutdown);
    pwm_d  = active ? (wave_q ^ ctrl.pol_main) : ctrl.pol_main;
    pwmc_d = active ? (!wave_q ^ ctrl.pol_comp) : ctrl.pol_comp;
    evt_d.overflow       = ovf;
    evt_d.underflow      = unf;
    evt_d.terminal_event = tc;
    evt_d.compare_hit    = hit || (cmd_wr && !run_q && ctrl.enable &&
                           pwdata[`PMC_CMD_RELOAD] && ctrl.mode[1] &&
                           cmp_q == `PMC_ZERO);
  end

  // Kill pin crosses in through two flops
  always_ff @(posedge pclk or posedge sys_rst) begin
    if (sys_rst) begin
      kill_meta_q <= 1'b0;
      kill_s_q    <= 1'b0;
    end else begin
      kill_meta_q <= kill_in;
      kill_s_q    <= kill_meta_q;
    end
  end

  always_ff @(posedge pclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q   <= `PMC_RST_CTRL;
      cyc_q    <= `PMC_RST_CYC;
      cyc_sh_q <= `PMC_RST_CYC;
      cmp_q    <= `PMC_RST_CMP;
      cmp_sh_q <= `PMC_RST_CMP;
      presc_q  <= `PMC_RST_PRESC;
      pcnt_q   <= `PMC_ZERO;
      cnt_q    <= `PMC_ZERO;
      dir_up_q <= 1'b1;
      run_q    <= 1'b0;
      pend_q   <= 1'b0;
      supp_q   <= 1'b0;
      wave_q   <= 1'b0;
      pwm_q    <= 1'b0;
      pwmc_q   <= 1'b0;
      evt_q    <= '0;
    end else begin
      ctrl_q   <= ctrl_d;
      cyc_q    <= cyc_d;
      cyc_sh_q <= cyc_sh_d;
      cmp_q    <= cmp_d;
      cmp_sh_q <= cmp_sh_d;
      presc_q  <= presc_d;
      pcnt_q   <= pcnt_d;
      cnt_q    <= cnt_d;
      dir_up_q <= dir_up_d;
      run_q    <= run_d;
      pend_q   <= pend_d;
      supp_q   <= supp_d;
      wave_q   <= wave_d;
      pwm_q    <= pwm_d;
      pwmc_q   <= pwmc_d;
      evt_q    <= evt_d;
    end
  end
endmodule // pmc_pwm_counter
`default_nettype wire

// ===== design/pmc_params.svh
// Register map, field positions and reset values of the PWM counter channel
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
`define PMC_W            16
`define PMC_AW           6
`define PMC_OFF_CTRL     6'h00
`define PMC_OFF_CMD      6'h04
`define PMC_OFF_STAT     6'h08
`define PMC_OFF_CNT      6'h0C
`define PMC_OFF_CYC      6'h10
`define PMC_OFF_CYC_SH   6'h14
`define PMC_OFF_CMP      6'h18
`define PMC_OFF_CMP_SH   6'h1C
`define PMC_OFF_PRESC    6'h20
`define PMC_CTRL_EN      0
`define PMC_CTRL_MODE_LO 1
`define PMC_CTRL_MODE_HI 2
`define PMC_CTRL_HALT    3
`define PMC_CTRL_LATCH   4
`define PMC_CTRL_POL     5
`define PMC_CTRL_POLC    6
`define PMC_CTRL_ACC     7
`define PMC_CTRL_APER    8
`define PMC_CTRL_SWCONST 9
`define PMC_CTRL_ONESHOT 10
`define PMC_CTRL_MSB     10
`define PMC_CMD_RELOAD   0
`define PMC_CMD_START    1
`define PMC_CMD_STOP     2
`define PMC_CMD_SWAP     3
`define PMC_RST_CTRL     11'h000
`define PMC_RST_CYC      16'hFFFF
`define PMC_RST_CMP      16'h0000
`define PMC_RST_PRESC    16'h0000
`define PMC_ZERO         16'h0000
`define PMC_ONE          16'h0001
`endif

// ===== design/pmc_pkg.sv
// Types shared by the PWM counter channel
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_ASCENDING  = 2'b00,
    PMC_DESCENDING = 2'b01,
    PMC_UPDN_SGL   = 2'b10,
    PMC_UPDN_DUAL  = 2'b11
  } pmc_mode_e;

  typedef struct packed {
    logic      one_shot;
    logic      swap_const;
    logic      auto_period;
    logic      auto_cc;
    logic      pol_comp;
    logic      pol_main;
    logic      latched_shutdown;
    logic      halt_on_shutdown;
    pmc_mode_e mode;
    logic      enable;
  } pmc_ctrl_s;

  typedef struct packed {
    logic overflow;
    logic underflow;
    logic terminal_event;
    logic compare_hit;
  } pmc_evt_s;
endpackage

// ===== bench/pmc_pwm_counter_properties.sv
// Port-level assertions for the PWM counter channel
`timescale 1ns/100ps
`default_nettype none
module pmc_pwm_counter_chk (
  input wire logic              pclk,
  input wire logic              sys_rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              kill_in,
  input wire logic              swap_group_out,
  input wire logic              pwm_out,
  input wire logic              pwm_comp_out,
  input wire pmc_pkg::pmc_evt_s evt_out
);
  pmc_pkg::pmc_ctrl_s ctrl_q, ctrl_d;
  pmc_pkg::pmc_mode_e md;
  logic [2:0]         age_q, age_d;
  logic               alt_q, alt_d;
  wire                wr = psel & penable & pready & pwrite;
  wire                cmd = wr && paddr == 32'h0000_0004;
  wire                ov = evt_out.overflow;
  wire                un = evt_out.underflow;
  wire                tc = evt_out.terminal_event;
  // Mode checks wait two cycles so trailing events of a stopped run are ignored
  wire                ok = age_q > 3'h1;
  wire                idle = pwm_out == ctrl_q.pol_main && pwm_comp_out == ctrl_q.pol_comp;
  assign md = ctrl_q.mode;

  always_comb begin
    ctrl_d = ctrl_q;
    age_d = age_q + 3'(age_q != 3'h7);
    alt_d = (cmd && pwdata[0]) ? 1'b0 : (ov | un) ? ov : alt_q;
    if (wr && paddr == 32'h0000_0000) begin
      ctrl_d = pmc_pkg::pmc_ctrl_s'(pwdata[10:0]);
      age_d = 3'h0;
    end
  end

  always_ff @(posedge pclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= '0;
      age_q <= 3'h0;
      alt_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      age_q <= age_d;
      alt_q <= alt_d;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (sys_rst);

  tc_ascend_a: assert property (
    ok && md == pmc_pkg::PMC_ASCENDING |-> tc == ov) else $error("tc not overflow");
  tc_under_a: assert property (
    ok && (md == pmc_pkg::PMC_DESCENDING || md == pmc_pkg::PMC_UPDN_SGL) |-> tc == un)
    else $error("tc not underflow");
  tc_dual_a: assert property (
    ok && md == pmc_pkg::PMC_UPDN_DUAL |-> tc == (ov | un)) else $error("tc not ov or un");
  dir_alternate_a: assert property (
    ok && md[1] && (ov || un) |-> ov != alt_q) else $error("ov and un not alternating");
  one_way_a: assert property (
    ok && !md[1] |-> !(md[0] ? ov : un)) else $error("wrong direction event");
  idle_level_a: assert property (
    !ctrl_q.enable && age_q == 3'h7 |-> idle) else $error("idle level wrong");
  kill_mask_a: assert property (
    (ctrl_q.enable && age_q == 3'h7 && kill_in) [*8] |-> idle) else $error("kill not masking");
  halt_stop_a: assert property (
    (ctrl_q.halt_on_shutdown && kill_in) [*6] |-> evt_out == 4'h0) else $error("halt still runs");
  swap_fanout_a: assert property (
    swap_group_out == (cmd && pwdata[3])) else $error("swap fan-out wrong");

  cover property (ov && md == pmc_pkg::PMC_UPDN_DUAL);
  cover property (evt_out.compare_hit && md[1]);
  cover property (kill_in && ctrl_q.latched_shutdown);
endmodule // pmc_pwm_counter_chk

bind pmc_pwm_counter pmc_pwm_counter_chk u_chk (
  .pclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .kill_in,
  .swap_group_out, .pwm_out, .pwm_comp_out, .evt_out);
`default_nettype wire

// ===== bench/pmc_load_model.sv
// Power stage load model: fault pin and drive-time counters
`timescale 1ns/100ps
`default_nettype none
module pmc_load_model (
  input  wire logic       clk,
  input  wire logic       pwm_out,
  input  wire logic       pwm_comp_out,
  input  wire logic       trip,
  input  wire logic       clear,
  output var  logic       fault,
  output var  logic [7:0] hi_cnt,
  output var  logic [7:0] lo_cnt
);
  // Fault is a level held as long as the overcurrent lasts
  always @(posedge clk) begin
    fault <= trip;
    hi_cnt <= clear ? 8'(pwm_out) : hi_cnt + 8'(pwm_out);
    lo_cnt <= clear ? 8'(pwm_comp_out) : lo_cnt + 8'(pwm_comp_out);
  end
endmodule // pmc_load_model
`default_nettype wire

// ===== bench/test_pwm_mode_counter.sv
// Directed bench for the PWM counter channel
`timescale 1ns/100ps
`default_nettype none
`include "pmc_params.svh"
module test_pwm_mode_counter;
  logic              pclk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic              kill, swap_in, trip, clear, pwm, pwm_n;
  logic [31:0]       paddr, pwdata, prdata;
  logic [7:0]        hi, lo;
  pmc_pkg::pmc_evt_s evt;
  wire  [3:0]        ev = evt;
  int                n_errors = 0;
  int                checked = 0;
  int                hits = 0;
  int                h0;

  pmc_pwm_counter u_dut (
    .pclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .kill_in(kill), .swap_group_in(swap_in),
    .swap_group_out(), .pwm_out(pwm), .pwm_comp_out(pwm_n), .evt_out(evt));
  pmc_load_model u_load (
    .clk(pclk), .pwm_out(pwm), .pwm_comp_out(pwm_n), .trip, .clear,
    .fault(kill), .hi_cnt(hi), .lo_cnt(lo));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    hits <= hits + int'(ev[0] === 1'b1);
  end

  task automatic final_report();
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic until_evt(input int b);
    for (int n = 0; ev[b] !== 1'b1; n++) begin
      if (n == 400) begin
        n_errors++;
        final_report();
      end
      @(posedge pclk);
    end
  endtask

  // Idle cycle after release so a following call never re-drives psel in one step
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 32'(a);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int n = 0; pready !== 1'b1; n++) begin
      if (n == 50) begin
        n_errors++;
        final_report();
      end
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic cfg(input logic [31:0] c, input logic [15:0] p, m, s);
    wr(`PMC_OFF_CMD, 32'h0000_0004);
    wr(`PMC_OFF_CTRL, c);
    wr(`PMC_OFF_CYC, 32'(p));
    wr(`PMC_OFF_CYC_SH, 32'(p));
    wr(`PMC_OFF_CMP, 32'(m));
    wr(`PMC_OFF_CMP_SH, 32'(s));
    h0 = hits;
    wr(`PMC_OFF_CMD, 32'h0000_0001);
  endtask

  // One full period between two events of bit b: length, high and low counts
  task automatic measure(input int b, input int p, input int h);
    int n;
    @(posedge pclk);
    until_evt(b);
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    for (n = 1; ev[b] !== 1'b1 && n < 300; n++) begin
      @(posedge pclk);
    end
    @(posedge pclk);
    check(32'(n), 32'(p));
    check(32'(hi), 32'(h));
    check(32'(lo), 32'(p - h));
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    int          cmp_t[3] = '{0, 2, 5};
    sys_rst = 1'b1;
    {psel, penable, pwrite, swap_in, trip, clear} = 6'h00;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    cyc(2);
    sys_rst <= 1'b0;
    @(posedge pclk);
    apb(1'b0, `PMC_OFF_CYC, 32'h0000_0000, r, e);
    check(r, 32'h0000_FFFF);
    apb(1'b0, 6'h24, 32'h0000_0000, r, e);
    check(32'(e), 32'h0000_0001);
    wr(`PMC_OFF_CTRL, 32'h0000_0060);
    cyc(3);
    check(32'({pwm, pwm_n}), 32'h0000_0003);
    foreach (cmp_t[i]) begin
      cfg(32'h0000_0181, 16'h0004, 16'(cmp_t[i]), 16'h0000);
      measure(3, 5, cmp_t[i]);
    end
    cfg(32'h0000_0181, 16'h0004, 16'h0002, 16'h0000);
    wr(`PMC_OFF_CYC_SH, 32'h0000_0006);
    wr(`PMC_OFF_CMP_SH, 32'h0000_0003);
    measure(3, 5, 2);
    wr(`PMC_OFF_CMD, 32'h0000_0008);
    measure(3, 7, 3);
    apb(1'b0, `PMC_OFF_CMP_SH, 32'h0000_0000, r, e);
    check(r, 32'h0000_0002);
    swap_in <= 1'b1;
    @(posedge pclk);
    swap_in <= 1'b0;
    measure(3, 5, 2);
    cfg(32'h0000_0183, 16'h0004, 16'h0002, 16'h0000);
    measure(2, 5, 3);
    cfg(32'h0000_0185, 16'h0004, 16'h0002, 16'h0000);
    measure(2, 8, 4);
    cfg(32'h0000_0185, 16'h0004, 16'h0000, 16'h0000);
    cyc(5);
    check(32'(hits - h0), 32'h0000_0001);
    cfg(32'h0000_0287, 16'h0004, 16'h0001, 16'h0002);
    measure(2, 8, 5);
    cfg(32'h0000_0181, 16'h0004, 16'h0002, 16'h0000);
    trip <= 1'b1;
    cyc(8);
    check(32'({pwm, pwm_n}), 32'h0000_0000);
    until_evt(3);
    trip <= 1'b0;
    measure(3, 5, 2);
    cfg(32'h0000_0191, 16'h0014, 16'h000A, 16'h0000);
    trip <= 1'b1;
    cyc(8);
    until_evt(3);
    trip <= 1'b0;
    cyc(6);
    check(32'(pwm), 32'h0000_0000);
    measure(3, 21, 10);
    cfg(32'h0000_0189, 16'h0004, 16'h0002, 16'h0000);
    trip <= 1'b1;
    cyc(8);
    trip <= 1'b0;
    cyc(4);
    apb(1'b0, `PMC_OFF_STAT, 32'h0000_0000, r, e);
    check(32'(r[0]), 32'h0000_0000);
    check(32'({pwm, pwm_n}), 32'h0000_0000);
    // Prescaled count clock: period and high time scale with presc+1
    wr(`PMC_OFF_PRESC, 32'h0000_0001);
    cfg(32'h0000_0181, 16'h0004, 16'h0002, 16'h0000);
    measure(3, 10, 4);
    // One-shot run stops itself at its first terminal event
    cfg(32'h0000_0581, 16'h0004, 16'h0002, 16'h0000);
    until_evt(3);
    cyc(2);
    apb(1'b0, `PMC_OFF_STAT, 32'h0000_0000, r, e);
    check(32'(r[0]), 32'h0000_0000);
    final_report();
  end
endmodule // test_pwm_mode_counter
`default_nettype wire
